// >>> src/meter_register_access.sv
// Purpose: host register port, rms pacing, unlock, dip/timeout take-up
// Assumes: serial port mode 3, frame cmd/addr/data msb first, cmd bit0 = read
// Notes: serial pins are sampled by CLK_I through three flops
`timescale 1ns/10ps
module meter_register_access #(
    parameter int LOOP_CYCLES = meter_regs_pkg::LOOP_CYCLES,
    parameter int RMS_GAP_CYCLES = meter_regs_pkg::RMS_GAP_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic SCLK_I,
    input wire logic SS_N_I,
    input wire logic MOSI_I,
    output logic MISO_O,
    output logic MISO_OE_O,
    input wire meter_regs_pkg::rms_set_type RMS_RESULTS_I,
    input wire logic PHASE_ABOVE_TENTH_I,
    output logic INTERRUPT_PIN_ZERO_N_O,
    output logic APPARENT_FAULT_O,
    output logic [7:0] ACCURACY_SETTING_O,
    output meter_regs_pkg::applied_type APPLIED_O
);
    localparam logic [15:0] LOOP_LAST = 16'(LOOP_CYCLES - 1);
    localparam logic [16:0] GAP_LAST = 17'(RMS_GAP_CYCLES - 1);

    meter_regs_pkg::state_type s_ff;
    meter_regs_pkg::state_type nxt_s;
    logic sample_set_ready_event;
    logic sclk_rise;
    logic sclk_fall;
    logic [55:0] new_rx;
    logic read_start;
    logic write_done;
    logic [15:0] op_addr;
    logic [31:0] wr_data;
    logic is_rms;
    logic rms_close;
    logic [2:0] rms_idx;
    logic [31:0] rd_word;

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    always_comb begin
        rd_word = 32'h00000000;
        case (op_addr)
            meter_regs_pkg::ADDR_ACCURACY_SETTING: rd_word = {24'h000000, s_ff.setting};
            meter_regs_pkg::ADDR_VOLTAGE_DIP_THRESHOLD: rd_word = {8'h00, s_ff.dip};
            meter_regs_pkg::ADDR_ZERO_CROSS_TIMEOUT_LIMIT: rd_word = {16'h0000, s_ff.zc};
            meter_regs_pkg::ADDR_RUN: rd_word = {31'h00000000, s_ff.run};
            default: begin
                if (is_rms) begin
                    rd_word = {8'h00, s_ff.snap[rms_idx]};
                end
            end
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        // pin filters: third flop must agree with second
        nxt_s.sclk_sy = {s_ff.sclk_sy[1:0], SCLK_I};
        nxt_s.ss_sy = {s_ff.ss_sy[1:0], SS_N_I};
        nxt_s.mosi_sy = {s_ff.mosi_sy[1:0], MOSI_I};
        if (s_ff.sclk_sy[1] == s_ff.sclk_sy[2]) begin
            nxt_s.sclk_f = s_ff.sclk_sy[2];
        end
        if (s_ff.ss_sy[1] == s_ff.ss_sy[2]) begin
            nxt_s.ss_f = s_ff.ss_sy[2];
        end
        if (s_ff.mosi_sy[1] == s_ff.mosi_sy[2]) begin
            nxt_s.mosi_f = s_ff.mosi_sy[2];
        end
        sclk_rise = !s_ff.ss_f && nxt_s.sclk_f && !s_ff.sclk_f;
        sclk_fall = !s_ff.ss_f && !nxt_s.sclk_f && s_ff.sclk_f;
        new_rx = {s_ff.rx[54:0], nxt_s.mosi_f};
        read_start = sclk_rise && s_ff.bit_cnt == meter_regs_pkg::ADDR_LAST_BIT
            && new_rx[16 + meter_regs_pkg::CMD_READ_BIT];
        write_done = sclk_rise && s_ff.bit_cnt == meter_regs_pkg::FRAME_LAST_BIT
            && !new_rx[48 + meter_regs_pkg::CMD_READ_BIT];
        op_addr = write_done ? new_rx[47:32] : new_rx[15:0];
        wr_data = new_rx[31:0];
        is_rms = op_addr >= meter_regs_pkg::ADDR_RMS_BASE
            && op_addr <= meter_regs_pkg::ADDR_RMS_LAST;
        rms_idx = 3'(op_addr - meter_regs_pkg::ADDR_RMS_BASE);
        rms_close = s_ff.rms_prev && s_ff.gap_cnt < GAP_LAST;

        // processing loop and ready interrupt
        sample_set_ready_event = s_ff.loop_cnt == LOOP_LAST;
        nxt_s.loop_cnt = sample_set_ready_event ? 16'h0000 : s_ff.loop_cnt + 16'h0001;
        if (sample_set_ready_event) begin
            nxt_s.snap = RMS_RESULTS_I;
            nxt_s.irq_n = 1'b0;
            nxt_s.irq_cnt = meter_regs_pkg::IRQ_LOW_CYCLES - 8'h01;
        end else if (s_ff.irq_cnt != 8'h00) begin
            nxt_s.irq_cnt = s_ff.irq_cnt - 8'h01;
        end else begin
            nxt_s.irq_n = 1'b1;
        end
        nxt_s.fault = s_ff.fault && !sample_set_ready_event;
        if (s_ff.gap_cnt != GAP_LAST) begin
            nxt_s.gap_cnt = s_ff.gap_cnt + 17'h00001;
        end

        // serial frame
        nxt_s.miso_oe = !s_ff.ss_f;
        if (s_ff.ss_f) begin
            nxt_s.bit_cnt = 6'h00;
        end else if (sclk_rise) begin
            nxt_s.rx = new_rx;
            nxt_s.bit_cnt = s_ff.bit_cnt + 6'h01;
        end else if (sclk_fall && s_ff.bit_cnt > meter_regs_pkg::DATA_FIRST_BIT) begin
            nxt_s.tx = {s_ff.tx[30:0], 1'b0};
        end
        if (read_start) begin
            nxt_s.tx = rd_word;
            nxt_s.armed = 1'b0;
            nxt_s.wr_run = 4'h0;
            nxt_s.last_wr = 16'h0000;
            if (is_rms) begin
                nxt_s.rms_prev = 1'b1;
                nxt_s.gap_cnt = 17'h00000;
                if (rms_close) begin
                    nxt_s.tx = ~rd_word;
                    nxt_s.fault = 1'b1;
                end
            end
        end

        // register writes
        if (write_done) begin
            nxt_s.armed = op_addr == meter_regs_pkg::ADDR_SETTING_UNLOCK_KEY
                && wr_data[7:0] == meter_regs_pkg::UNLOCK_KEY_VALUE;
            nxt_s.last_wr = op_addr;
            if (op_addr == s_ff.last_wr && s_ff.wr_run != 4'hF) begin
                nxt_s.wr_run = s_ff.wr_run + 4'h1;
            end else if (op_addr != s_ff.last_wr) begin
                nxt_s.wr_run = 4'h1;
            end
            if (op_addr == meter_regs_pkg::ADDR_ACCURACY_SETTING && s_ff.armed) begin
                nxt_s.setting = wr_data[7:0];
            end
            if (op_addr == meter_regs_pkg::ADDR_RUN) begin
                nxt_s.run = wr_data[0];
            end
            if (op_addr == meter_regs_pkg::ADDR_VOLTAGE_DIP_THRESHOLD) begin
                nxt_s.dip = wr_data[23:0];
                if (nxt_s.wr_run >= meter_regs_pkg::WRITE_REPEAT_APPLY) begin
                    nxt_s.dip_live = 1'b1;
                end
            end
            if (op_addr == meter_regs_pkg::ADDR_ZERO_CROSS_TIMEOUT_LIMIT) begin
                nxt_s.zc = wr_data[15:0];
                if (nxt_s.wr_run >= meter_regs_pkg::WRITE_REPEAT_APPLY) begin
                    nxt_s.zc_live = 1'b1;
                end
            end
        end

        // dip and timeout take-up
        if (PHASE_ABOVE_TENTH_I) begin
            nxt_s.seen = 1'b1;
            nxt_s.dip_live = 1'b1;
            nxt_s.zc_live = 1'b1;
        end
        nxt_s.applied.voltage_dip_threshold = (s_ff.run && s_ff.dip_live) ?
            s_ff.dip : meter_regs_pkg::DIP_RESET;
        nxt_s.applied.zero_cross_timeout_limit = (s_ff.run && s_ff.zc_live) ?
            s_ff.zc : meter_regs_pkg::ZC_RESET;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_ff <= meter_regs_pkg::STATE_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign MISO_O = s_ff.tx[31];
    assign MISO_OE_O = s_ff.miso_oe;
    assign INTERRUPT_PIN_ZERO_N_O = s_ff.irq_n;
    assign APPARENT_FAULT_O = s_ff.fault;
    assign ACCURACY_SETTING_O = s_ff.setting;
    assign APPLIED_O = s_ff.applied;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    sequence loop_tick;
        sample_set_ready_event;
    endsequence
    sequence key_written;
        write_done && op_addr == meter_regs_pkg::ADDR_SETTING_UNLOCK_KEY
            && wr_data[7:0] == meter_regs_pkg::UNLOCK_KEY_VALUE;
    endsequence
    sequence setting_written;
        write_done && op_addr == meter_regs_pkg::ADDR_ACCURACY_SETTING;
    endsequence

    a_loop_period: assert property (loop_tick |=> (s_ff.loop_cnt == 16'h0000) ##1
        (s_ff.loop_cnt == 16'h0001 && !sample_set_ready_event))
        else $error("loop counter did not restart after tick");
    a_ready_irq_low: assert property (loop_tick |=> !INTERRUPT_PIN_ZERO_N_O [*8])
        else $error("ready interrupt not asserted after loop tick");
    a_close_rms_bad: assert property (read_start && is_rms && rms_close
        |=> APPARENT_FAULT_O && MISO_O == !$past(rd_word[31]))
        else $error("close rms read not corrupted");
    a_far_rms_clean: assert property (read_start && is_rms && !rms_close
        |=> s_ff.tx == $past(rd_word))
        else $error("spaced rms read corrupted");
    a_fault_recovers: assert property (loop_tick and !(read_start && is_rms && rms_close)
        |=> !APPARENT_FAULT_O)
        else $error("apparent fault persisted past loop");
    a_other_free: assert property (read_start && !is_rms && !APPARENT_FAULT_O
        |=> !APPARENT_FAULT_O && s_ff.tx == $past(rd_word))
        else $error("non-rms read restricted");
    a_key_arms: assert property (key_written |=> s_ff.armed)
        else $error("unlock key did not arm");
    a_unlock_sets: assert property (setting_written and s_ff.armed
        |=> ACCURACY_SETTING_O == $past(wr_data[7:0]))
        else $error("armed setting write not captured");
    a_unarmed_ignored: assert property (setting_written and !s_ff.armed
        |=> $stable(ACCURACY_SETTING_O))
        else $error("unarmed setting write took effect");
    a_setting_readback: assert property (read_start
        && op_addr == meter_regs_pkg::ADDR_ACCURACY_SETTING
        |=> s_ff.tx[7:0] == ACCURACY_SETTING_O)
        else $error("setting readback wrong");
    a_dip_applied: assert property (s_ff.run && s_ff.dip_live
        |=> APPLIED_O.voltage_dip_threshold == $past(s_ff.dip))
        else $error("dip threshold not applied");
    a_dip_withheld: assert property (!s_ff.dip_live && !PHASE_ABOVE_TENTH_I
        |=> APPLIED_O.voltage_dip_threshold == meter_regs_pkg::DIP_RESET)
        else $error("dip threshold applied too early");
endmodule

// >>> inc/meter_regs_pkg.sv
// Purpose: constants and types of the metering register access block
// Assumes: 250 MHz core clock
// Notes: rms results refresh once per 125 us loop (8 kHz)
package meter_regs_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int LOOP_PERIOD_NS = 125000;
    localparam int LOOP_CYCLES = LOOP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int RMS_GAP_NS = 265000;
    localparam int RMS_GAP_CYCLES = (RMS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_LOW_NS = 1000;
    localparam logic [7:0] IRQ_LOW_CYCLES = 8'(IRQ_LOW_NS / CLK_PERIOD_NS);
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [15:0] ADDR_ACCURACY_SETTING = 16'hE7E2;
    localparam logic [15:0] ADDR_SETTING_UNLOCK_KEY = 16'hE7FE;
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hAD;
    localparam logic [15:0] ADDR_RMS_BASE = 16'h43C0;
    localparam logic [15:0] ADDR_RMS_LAST = 16'h43C6;
    localparam logic [2:0] PHASE_A_VOLTAGE_RMS_RESULT = 3'h0;
    localparam logic [2:0] PHASE_B_VOLTAGE_RMS_RESULT = 3'h1;
    localparam logic [2:0] PHASE_C_VOLTAGE_RMS_RESULT = 3'h2;
    localparam logic [2:0] PHASE_A_CURRENT_RMS_RESULT = 3'h3;
    localparam logic [2:0] PHASE_B_CURRENT_RMS_RESULT = 3'h4;
    localparam logic [2:0] PHASE_C_CURRENT_RMS_RESULT = 3'h5;
    localparam logic [2:0] NEUTRAL_CURRENT_RMS_RESULT = 3'h6;
    localparam logic [15:0] ADDR_VOLTAGE_DIP_THRESHOLD = 16'hE500;
    localparam logic [15:0] ADDR_ZERO_CROSS_TIMEOUT_LIMIT = 16'hE501;
    localparam logic [15:0] ADDR_RUN = 16'hE502;
    localparam logic [7:0] SETTING_RESET = 8'h00;
    localparam logic [23:0] DIP_RESET = 24'h000000;
    localparam logic [15:0] ZC_RESET = 16'hFFFF;
    localparam logic [3:0] WRITE_REPEAT_APPLY = 4'h8;
    // ----------------------------------------
    // serial frame: cmd 8, address 16, data 32, msb first
    // ----------------------------------------
    localparam int CMD_READ_BIT = 0;
    localparam logic [5:0] ADDR_LAST_BIT = 6'h17;
    localparam logic [5:0] DATA_FIRST_BIT = 6'h18;
    localparam logic [5:0] FRAME_LAST_BIT = 6'h37;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef logic [6:0][23:0] rms_set_type;
    typedef struct packed {
        logic [23:0] voltage_dip_threshold;
        logic [15:0] zero_cross_timeout_limit;
    } applied_type;
    typedef struct packed {
        logic [2:0] sclk_sy;
        logic [2:0] ss_sy;
        logic [2:0] mosi_sy;
        logic sclk_f;
        logic ss_f;
        logic mosi_f;
        logic [5:0] bit_cnt;
        logic [55:0] rx;
        logic [31:0] tx;
        logic miso_oe;
        logic [15:0] loop_cnt;
        logic [16:0] gap_cnt;
        logic rms_prev;
        logic [7:0] irq_cnt;
        logic irq_n;
        logic fault;
        rms_set_type snap;
        logic armed;
        logic [7:0] setting;
        logic [23:0] dip;
        logic [15:0] zc;
        logic run;
        logic seen;
        logic dip_live;
        logic zc_live;
        logic [15:0] last_wr;
        logic [3:0] wr_run;
        applied_type applied;
    } state_type;
    localparam state_type STATE_RESET = '{sclk_sy: 3'h7, ss_sy: 3'h7, sclk_f: 1'b1,
        ss_f: 1'b1, irq_n: 1'b1, setting: SETTING_RESET, dip: DIP_RESET, zc: ZC_RESET,
        applied: '{DIP_RESET, ZC_RESET}, default: '0};
endpackage

// >>> verification/serial_host_model.sv
// Purpose: host on the serial register port, mode 3 frames
// Assumes: four core cycles per serial clock half period (32 ns period)
// Notes: released data line reads as inverse of its last bit
`timescale 1ns/10ps
module serial_host_model (
    input wire logic CLK_I,
    output logic SCLK_O,
    output logic SS_N_O,
    output logic MOSI_O,
    input wire logic MISO_I,
    input wire logic MISO_OE_I
);
    logic last = 1'b0;
    logic seen;
    initial begin
        SCLK_O = 1'b1;
        SS_N_O = 1'b1;
        MOSI_O = 1'b0;
    end
    // undriven line shows inverse of last value
    always_comb seen = MISO_OE_I ? MISO_I : ~last;
    always @(posedge CLK_I) if (MISO_OE_I) last <= MISO_I;
    task automatic half();
        repeat (4) @(posedge CLK_I);
    endtask
    // ----------------
    // whole frame: cmd, address, data, msb first
    // ----------------
    task automatic frame(input logic [7:0] cmd, input logic [15:0] addr,
        input logic [31:0] wdata, output logic [31:0] rdata);
        logic [55:0] sh;
        sh = {cmd, addr, wdata};
        rdata = '0;
        @(posedge CLK_I);
        SS_N_O <= 1'b0;
        half();
        for (int i = 55; i >= 0; i--) begin
            SCLK_O <= 1'b0;
            MOSI_O <= sh[i];
            half();
            SCLK_O <= 1'b1;
            half();
            // taken late in the high half: the device shifts on the edge of our fall
            if (i < 32) rdata[i] = seen;
        end
        SS_N_O <= 1'b1;
        MOSI_O <= ~sh[0];
        half();
        half();
    endtask
endmodule

// >>> verification/tb.sv
// Purpose: self-checking bench of the meter register port
// Assumes: shortened loop 400 and rms gap 848 cycles
// Notes: frames last about 461 cycles
`timescale 1ns/10ps
module tb;
    localparam int LOOP = 400;
    localparam int GAP = 848;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, ss_n, mosi, miso, miso_oe, irq_n, fault;
    logic above = 1'b0;
    meter_regs_pkg::rms_set_type rms = '0;
    meter_regs_pkg::applied_type applied;
    logic [7:0] setting;
    logic [31:0] rd;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n_flt = 0;
    int f0;
    time t0;
    always #2 clk = ~clk;
    meter_register_access #(.LOOP_CYCLES(LOOP), .RMS_GAP_CYCLES(GAP)) meter_register_access_i (
        .CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .SS_N_I(ss_n), .MOSI_I(mosi),
        .MISO_O(miso), .MISO_OE_O(miso_oe), .RMS_RESULTS_I(rms),
        .PHASE_ABOVE_TENTH_I(above), .INTERRUPT_PIN_ZERO_N_O(irq_n),
        .APPARENT_FAULT_O(fault), .ACCURACY_SETTING_O(setting), .APPLIED_O(applied));
    serial_host_model serial_host_model_i (.CLK_I(clk), .SCLK_O(sclk), .SS_N_O(ss_n),
        .MOSI_O(mosi), .MISO_I(miso), .MISO_OE_I(miso_oe));
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fault === 1'b1) n_flt <= n_flt + 1;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
        serial_host_model_i.frame(8'h01, a, 32'h00000000, d);
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        serial_host_model_i.frame(8'h00, a, d, x);
    endtask
    task automatic irq_wait(input int n);
        repeat (n) @(negedge irq_n);
        @(posedge clk);
        #1;
    endtask
    function automatic logic [31:0] rv(input int k);
        return {8'h00, rms[k]};
    endfunction
    // ----------------
    // main sequence
    // ----------------
    initial begin
        for (int k = 0; k < 7; k++) rms[k] <= {4'(k + 1), 20'h5A5A5};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({31'h0, irq_n}, 32'h00000001);
        check({31'h0, miso_oe}, 32'h00000000);
        check({24'h0, setting}, {24'h0, meter_regs_pkg::SETTING_RESET});
        check({8'h0, applied.voltage_dip_threshold}, {8'h0, meter_regs_pkg::DIP_RESET});
        @(negedge irq_n);
        t0 = $time;
        @(negedge irq_n);
        check(32'(($time - t0) / 4), 32'(LOOP));
        irq_wait(1);
        // paced on every third interrupt
        for (int k = 0; k < 7; k++) begin
            rd_reg(meter_regs_pkg::ADDR_RMS_BASE + 16'(k), rd);
            check(rd, rv(k));
            irq_wait(3);
        end
        check(32'(n_flt), 32'h00000000);
        rd_reg(meter_regs_pkg::ADDR_RMS_BASE, rd);
        check(rd, rv(0));
        f0 = n_flt;
        rd_reg(meter_regs_pkg::ADDR_RMS_BASE + 16'h0001, rd);
        check(rd, ~rv(1));
        check({31'h0, n_flt > f0}, 32'h00000001);
        irq_wait(1);
        check({31'h0, fault}, 32'h00000000);
        rd_reg(meter_regs_pkg::ADDR_ACCURACY_SETTING, rd);
        check(rd, 32'h00000000);
        irq_wait(3);
        rd_reg(meter_regs_pkg::ADDR_RMS_BASE + 16'h0002, rd);
        check(rd, rv(2));
        // setting without key, and with an operation between
        wr_reg(meter_regs_pkg::ADDR_ACCURACY_SETTING, 32'h00000001);
        rd_reg(meter_regs_pkg::ADDR_ACCURACY_SETTING, rd);
        check(rd, 32'h00000000);
        wr_reg(meter_regs_pkg::ADDR_SETTING_UNLOCK_KEY, 32'h000000AD);
        rd_reg(meter_regs_pkg::ADDR_SETTING_UNLOCK_KEY, rd);
        check(rd, 32'h00000000);
        wr_reg(meter_regs_pkg::ADDR_ACCURACY_SETTING, 32'h00000001);
        rd_reg(meter_regs_pkg::ADDR_ACCURACY_SETTING, rd);
        check(rd, 32'h00000000);
        wr_reg(meter_regs_pkg::ADDR_SETTING_UNLOCK_KEY, 32'h000000AD);
        wr_reg(meter_regs_pkg::ADDR_ACCURACY_SETTING, 32'h00000001);
        rd_reg(meter_regs_pkg::ADDR_ACCURACY_SETTING, rd);
        check(rd, 32'h00000001);
        check({24'h0, setting}, 32'h00000001);
        rd_reg(16'h1234, rd);
        check(rd, 32'h00000000);
        // dip and timeout take-up
        wr_reg(meter_regs_pkg::ADDR_RUN, 32'h00000001);
        wr_reg(meter_regs_pkg::ADDR_VOLTAGE_DIP_THRESHOLD, 32'h00123456);
        wr_reg(meter_regs_pkg::ADDR_ZERO_CROSS_TIMEOUT_LIMIT, 32'h00001234);
        check({8'h0, applied.voltage_dip_threshold}, 32'h00000000);
        repeat (8) wr_reg(meter_regs_pkg::ADDR_VOLTAGE_DIP_THRESHOLD, 32'h00123456);
        check({8'h0, applied.voltage_dip_threshold}, 32'h00123456);
        check({16'h0, applied.zero_cross_timeout_limit}, 32'h0000FFFF);
        @(posedge clk);
        above <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({16'h0, applied.zero_cross_timeout_limit}, 32'h00001234);
        close_out();
    end
endmodule
